/* File: dlas_sequencer.sv */
// sequencer for two separately controlled lifting axles
`timescale 1ns/1ps
module dlas_sequencer
   import dlas_pkg::*;
#(
   parameter int WATCH_TICKS = DLAS_WATCH_TICKS,
   parameter int DELAY_TICKS = DLAS_DELAY_TICKS,
   parameter int TICK_DIV = DLAS_TICK_DIV
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [DLAS_PW-1:0] pressure_sample,
   input wire dlas_thresh_t thresh,
   input wire logic ignition_on,
   input wire logic traction_request,
   input wire logic manoeuvre_request,
   input wire logic below_speed_limit,
   output dlas_valve_t valves,
   output logic traction_active
);
   // the four discrete pin inputs pass two flip-flops; pressure_sample is registered once per tick
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [DLAS_PW-1:0] p;
      dlas_state_t state;
      logic [DLAS_TW-1:0] cnt;
      logic ax1_up;
      logic ax2_up;
      logic th_act;
   } dlas_st_t;
   dlas_st_t st_reg, st_next;

   logic tick;
   logic ign, trq, mrq, slow;
   logic p_ge_low, p_lt_r1, p_lt_r2, p_lt_comb, p_lt_th;

   dlas_tick_div #(.DIV(TICK_DIV)) u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick)
   );

   // synchronised inputs, read from second stage only
   assign ign = st_reg.s2[0];
   assign trq = st_reg.s2[1];
   assign mrq = st_reg.s2[2];
   assign slow = st_reg.s2[3];

   assign p_ge_low = st_reg.p >= thresh.axle_lowering_pressure;
   assign p_lt_r1 = st_reg.p < thresh.first_axle_raising_pressure;
   assign p_lt_r2 = st_reg.p < thresh.second_axle_raising_pressure;
   assign p_lt_comb = st_reg.p < thresh.combined_raising_pressure;
   assign p_lt_th = st_reg.p < thresh.traction_limit_pressure;

   // next state of the sequencer
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = {below_speed_limit, manoeuvre_request, traction_request, ignition_on};
      st_next.s2 = st_reg.s1;
      st_next.th_act = ign && (trq || mrq) && slow && p_lt_th;
      if (tick)
      begin
         st_next.p = pressure_sample;
         if (st_reg.cnt != '0)
            st_next.cnt = st_reg.cnt - DLAS_TW'(1);
         if (!ign)
         begin
            st_next.state = DLAS_ST_IDLE;
         end
         else
         begin
            unique case (st_reg.state)
               DLAS_ST_IDLE:
               begin
                  // not while traction help holds the second axle
                  if (p_lt_comb && !st_reg.ax1_up && !st_reg.ax2_up && !st_reg.th_act)
                  begin
                     st_next.ax1_up = 1'b1;
                     st_next.ax2_up = 1'b1;
                  end
                  else if (p_lt_r2 && !st_reg.ax2_up && !st_reg.th_act)
                  begin
                     if (st_reg.ax1_up)
                        st_next.ax2_up = 1'b1;
                     else
                     begin
                        st_next.ax2_up = 1'b1;
                        st_next.state = DLAS_ST_RAISE_WAIT;
                        st_next.cnt = DLAS_TW'(DELAY_TICKS);
                     end
                  end
                  else if (p_lt_r1 && !st_reg.ax1_up)
                  begin
                     st_next.ax1_up = 1'b1;
                  end
                  else if (p_ge_low && st_reg.ax2_up && !st_reg.th_act)
                  begin
                     st_next.ax2_up = 1'b0;
                     st_next.state = DLAS_ST_WATCH;
                     st_next.cnt = DLAS_TW'(WATCH_TICKS);
                  end
                  else if (p_ge_low && st_reg.ax1_up && !st_reg.ax2_up)
                  begin
                     st_next.state = DLAS_ST_LOWER_WAIT;
                     st_next.cnt = DLAS_TW'(DELAY_TICKS);
                  end
               end
               DLAS_ST_WATCH:
               begin
                  if (!p_ge_low)
                     st_next.state = DLAS_ST_IDLE;
                  else if (st_reg.cnt == '0)
                  begin
                     st_next.state = DLAS_ST_LOWER_WAIT;
                     st_next.cnt = DLAS_TW'(DELAY_TICKS);
                  end
               end
               DLAS_ST_LOWER_WAIT:
               begin
                  if (st_reg.cnt == '0)
                  begin
                     if (p_ge_low)
                        st_next.ax1_up = 1'b0;
                     st_next.state = DLAS_ST_IDLE;
                  end
               end
               DLAS_ST_RAISE_WAIT:
               begin
                  if (st_reg.cnt == '0)
                  begin
                     if (p_lt_r2)
                        st_next.ax1_up = 1'b1;
                     st_next.state = DLAS_ST_IDLE;
                  end
               end
               default:
                  st_next.state = DLAS_ST_IDLE;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.state <= DLAS_ST_IDLE;
         st_reg.ax1_up <= DLAS_AXLE_UP;
         st_reg.ax2_up <= DLAS_AXLE_UP;
      end
      else
         st_reg <= st_next;
   end

   assign valves.first_axle_valve_connector = st_reg.ax1_up || st_reg.th_act;
   assign valves.second_axle_valve_connector = st_reg.ax2_up;
   assign traction_active = st_reg.th_act;

   a_second_hold_th: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.th_act |=> $stable(st_reg.ax2_up))
      else $error("second axle moved during traction help");

   a_lower_order: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(st_reg.ax1_up) |-> !st_reg.ax2_up)
      else $error("first axle lowered before second");

   // second axle never rises alone unless the first raise is pending
   a_raise_order: assert property (@(posedge sys_clk) disable iff (rst)
      ($rose(st_reg.ax2_up) && !$past(st_reg.ax1_up)) |-> (st_reg.ax1_up || st_reg.state == DLAS_ST_RAISE_WAIT))
      else $error("second axle raised ahead of first");

   a_speed_gate: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.th_act |-> $past(slow))
      else $error("traction help above speed limit");

   a_relief_first: assert property (@(posedge sys_clk) disable iff (rst)
      st_reg.th_act |-> valves.first_axle_valve_connector)
      else $error("traction relief missing on first axle");

   a_watch_load: assert property (@(posedge sys_clk) disable iff (rst)
      (st_reg.state != DLAS_ST_WATCH ##1 st_reg.state == DLAS_ST_WATCH) |-> st_reg.cnt == DLAS_TW'(WATCH_TICKS))
      else $error("watch interval wrong");

   a_both_raise: assert property (@(posedge sys_clk) disable iff (rst)
      (tick && ign && st_reg.state == DLAS_ST_IDLE && p_lt_comb && !st_reg.ax1_up && !st_reg.ax2_up && !st_reg.th_act)
      |=> st_reg.ax1_up && st_reg.ax2_up)
      else $error("combined raise failed");

   a_second_lower: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(st_reg.ax2_up) |-> st_reg.state == DLAS_ST_WATCH && $past(p_ge_low))
      else $error("second axle lowered without threshold");
endmodule : dlas_sequencer

/* File: dlas_pkg.sv */
// shared types and constants for the dual lift axle sequencer
package dlas_pkg;
   localparam int DLAS_PW = 12;                  // pressure sample width, sensor counts
   localparam int DLAS_CLK_HZ = 10_000_000;      // system clock rate
   localparam int DLAS_TICK_HZ = 10;             // control tick rate
   localparam int DLAS_TICK_DIV = DLAS_CLK_HZ / DLAS_TICK_HZ;
   localparam int DLAS_WATCH_S = 30;             // watch interval after second axle lowers
   localparam int DLAS_DELAY_S = 15;             // delay before first axle follows
   localparam int DLAS_WATCH_TICKS = DLAS_WATCH_S * DLAS_TICK_HZ;
   localparam int DLAS_DELAY_TICKS = DLAS_DELAY_S * DLAS_TICK_HZ;
   localparam int DLAS_TW = 10;                  // tick counter width
   localparam logic DLAS_AXLE_UP = 1'b1;         // reset value of each axle command

   // configured thresholds, all in sensor counts
   typedef struct packed {
      logic [DLAS_PW-1:0] axle_lowering_pressure;
      logic [DLAS_PW-1:0] first_axle_raising_pressure;
      logic [DLAS_PW-1:0] second_axle_raising_pressure;
      logic [DLAS_PW-1:0] combined_raising_pressure;
      logic [DLAS_PW-1:0] traction_limit_pressure;
   } dlas_thresh_t;

   // valve commands, 1 = lift (relieve bellows)
   typedef struct packed {
      logic first_axle_valve_connector;
      logic second_axle_valve_connector;
   } dlas_valve_t;

   typedef enum logic [2:0] {
      DLAS_ST_IDLE,
      DLAS_ST_WATCH,
      DLAS_ST_LOWER_WAIT,
      DLAS_ST_RAISE_WAIT
   } dlas_state_t;
endpackage : dlas_pkg

/* File: dlas_tick_div.sv */
// one-cycle control tick enable from the system clock
`timescale 1ns/1ps
module dlas_tick_div
   import dlas_pkg::*;
#(
   parameter int DIV = DLAS_TICK_DIV
)(
   input wire logic sys_clk,
   input wire logic rst,
   output logic tick
);
   typedef struct packed {
      logic [23:0] cnt;
      logic tick;
   } dlas_div_st_t;
   dlas_div_st_t st_reg, st_next;

   // count down and pulse at wrap
   always_comb
   begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == 24'h00_0000)
      begin
         st_next.cnt = 24'(DIV - 1);
         st_next.tick = 1'b1;
      end
      else
      begin
         st_next.cnt = st_reg.cnt - 24'h00_0001;
      end
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign tick = st_reg.tick;
endmodule : dlas_tick_div

/* File: dlas_valve_model.sv */
// bellows model behind the two lifting axle valve outputs
`timescale 1ns/1ps
module dlas_valve_model
   import dlas_pkg::*;
#(
   parameter int SETTLE = 3
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire dlas_valve_t valves,
   output logic first_lifted,
   output logic second_lifted
);
   logic [SETTLE-1:0] first_sr_reg;
   logic [SETTLE-1:0] second_sr_reg;

   // separate valve paths
   // each lifting bellows follows only its own valve, after a settle time
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         first_sr_reg <= '1;
         second_sr_reg <= '1;
      end
      else
      begin
         first_sr_reg <= {first_sr_reg[SETTLE-2:0], valves.first_axle_valve_connector};
         second_sr_reg <= {second_sr_reg[SETTLE-2:0], valves.second_axle_valve_connector}; // spring return
      end
   end

   // settled axle positions
   assign first_lifted = first_sr_reg[SETTLE-1];
   assign second_lifted = second_sr_reg[SETTLE-1];
endmodule : dlas_valve_model

/* File: tb_top.sv */
// self-checking bench for the dual lift axle sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin error_cnt++; \
   $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_top
   import dlas_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [DLAS_PW-1:0] p;
   dlas_thresh_t th;
   logic ign;
   logic trq;
   logic mrq;
   logic spd;
   dlas_valve_t valves;
   logic tr_act;
   logic m1;
   logic m2;
   int error_cnt = 0;
   int checks_done = 0;

   // 100 ns clock
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   dlas_sequencer #(.WATCH_TICKS(5), .DELAY_TICKS(3), .TICK_DIV(10)) dut (
      .sys_clk(sys_clk), .rst(rst), .pressure_sample(p), .thresh(th), .ignition_on(ign),
      .traction_request(trq), .manoeuvre_request(mrq), .below_speed_limit(spd),
      .valves(valves), .traction_active(tr_act));

   dlas_valve_model model (.sys_clk(sys_clk), .rst(rst), .valves(valves), .first_lifted(m1), .second_lifted(m2));

   // verdict and end of run
   task summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // advance n clocks, landing just after the edge
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   // wait for the next valve change, then compare it whole
   task wait_v(input dlas_valve_t ex, input string nm);
      dlas_valve_t st;
      int i;
      st = valves;
      i = 0;
      while (valves === st && i < 200)
      begin
         step(1);
         i++;
      end
      if (i == 200)
      begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", nm, ex, valves);
         summarize();
      end
      `CHK(nm, ex, valves)
   endtask : wait_v

   // load from empty until both axles are down
   task load(input string nm);
      p = 12'h0420;
      wait_v(2'h2, nm);
      step(99);
      `CHK(nm, 2'h2, valves)
      wait_v(2'h0, nm);
      $display("test %s done", nm);
   endtask : load

   initial
   begin
      ign = 1'b0;
      trq = 1'b0;
      mrq = 1'b0;
      spd = 1'b1;
      p = 12'h0420;
      th.combined_raising_pressure = 12'h0111;
      th.second_axle_raising_pressure = 12'h0191;
      th.first_axle_raising_pressure = 12'h0266;
      th.axle_lowering_pressure = 12'h0400;
      th.traction_limit_pressure = 12'h0533;
      // second raise below first, combined between empty and second
      step(16);
      rst = 1'b0;
      `CHK("reset valves", 2'h3, valves)
      `CHK("reset traction", 1'h0, tr_act)
      step(60);
      `CHK("ignition off hold", 2'h3, valves)
      $display("test reset done");
      ign = 1'b1;
      load("loading");
      trq = 1'b1;
      wait_v(2'h2, "traction relief");
      `CHK("traction active", 1'h1, tr_act)
      spd = 1'b0;
      wait_v(2'h0, "speed limit");
      `CHK("traction off", 1'h0, tr_act)
      trq = 1'b0;
      spd = 1'b1;
      step(10);
      mrq = 1'b1;
      wait_v(2'h2, "manoeuvre relief");
      p = 12'h0600;
      wait_v(2'h0, "manoeuvre limit");
      mrq = 1'b0;
      p = 12'h0420;
      step(30);
      $display("test relief done");
      p = 12'h0200;
      wait_v(2'h2, "unload first");
      step(60);
      `CHK("unload hold", 2'h2, valves)
      p = 12'h0150;
      wait_v(2'h3, "unload second");
      trq = 1'b1;
      p = 12'h0420;
      step(80);
      `CHK("traction freeze", 2'h3, valves)
      `CHK("traction up", 1'h1, tr_act)
      trq = 1'b0;
      wait_v(2'h2, "watch start");
      p = 12'h0300;
      step(150);
      `CHK("watch cancel", 2'h2, valves)
      p = 12'h0420;
      wait_v(2'h0, "late lower");
      p = 12'h0050;
      wait_v(2'h3, "combined again");
      $display("test hold done");
      load("reload");
      p = 12'h0150;
      wait_v(2'h1, "staged second");
      step(39);
      `CHK("staged delay", 2'h1, valves)
      wait_v(2'h3, "staged first");
      load("reload");
      p = 12'h0050;
      wait_v(2'h3, "combined raise");
      load("reload");
      p = 12'h0150;
      wait_v(2'h1, "cancel second");
      p = 12'h0300;
      step(80);
      `CHK("cancel first", 2'h1, valves)
      `CHK("bellows first", 1'h0, m1)
      `CHK("bellows second", 1'h1, m2)
      $display("test raise done");
      // manoeuvring set: lowering below empty, first raise at half of lowering
      th.axle_lowering_pressure = 12'h0040;
      th.first_axle_raising_pressure = 12'h0020;
      th.second_axle_raising_pressure = 12'h0018;
      th.combined_raising_pressure = 12'h0010;
      th.traction_limit_pressure = 12'h0053;
      p = 12'h0048;
      wait_v(2'h0, "manoeuvre ground");
      mrq = 1'b1;
      wait_v(2'h2, "manoeuvre aid");
      `CHK("manoeuvre active", 1'h1, tr_act)
      mrq = 1'b0;
      wait_v(2'h0, "manoeuvre end");
      $display("test manoeuvre done");
      summarize();
   end
endmodule : tb_top
